// ### inc/tqu_pkg.sv
package tqu_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [11:0] ID_OFS = 12'h000;
  localparam logic [11:0] EN_OFS = 12'h004;
  localparam logic [3:0] GEN_PAGE = 4'h1;
  localparam logic [3:0] SEC_PAGE = 4'h2;
  localparam logic [3:0] GST_PAGE = 4'h3;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] SID_OFS = 8'h08;
  localparam logic [7:0] SSID_OFS = 8'h0C;
  localparam logic [7:0] ALO_OFS = 8'h10;
  localparam logic [7:0] AHI_OFS = 8'h14;
  localparam logic [7:0] RLO_OFS = 8'h18;
  localparam logic [7:0] RHI_OFS = 8'h1C;
  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int RUN_BIT = 0;
  localparam int SECURE_STREAM_SELECT_BIT = 31;
  localparam int SSIDV_BIT = 30;
  localparam int TYPE_LSB = 8;
  localparam int WR_BIT = 4;
  localparam int INSTR_BIT = 5;
  localparam int PRIV_BIT = 6;
  localparam int EN_NS_BIT = 0;
  localparam int EN_S_BIT = 1;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [1:0] RST_EN = 2'h0;
  // ---------------------------------------------------------------
  // options, groups and fault codes
  // ---------------------------------------------------------------
  localparam logic QUERY_PRESENT = 1'b1;
  localparam logic SECURE_PRESENT = 1'b1;
  localparam logic GUEST_PRESENT = 1'b1;
  localparam logic [1:0] G_GEN = 2'h0;
  localparam logic [1:0] G_SEC = 2'h1;
  localparam logic [1:0] G_GST = 2'h2;
  localparam logic [1:0] G_NONE = 2'h3;
  localparam logic [7:0] FC_INVALID_REQUEST_ERROR = 8'h01;
  localparam logic [7:0] FC_INV_STAGE = 8'h02;
  localparam logic [7:0] FC_WORLD = 8'h03;
  typedef enum logic [1:0] {
    SC_RSVD = 2'b00, SC_S1 = 2'b01, SC_S2 = 2'b10, SC_BOTH = 2'b11
  } tqu_scope_t;
  typedef struct packed {
    logic [1:0] grp;
    logic secure;
    logic [15:0] stream;
    logic ssid_valid;
    logic [19:0] ssid;
    tqu_scope_t scope;
    logic wr;
    logic instr;
    logic priv;
    logic [63:0] addr;
  } tqu_req_t;
  typedef struct packed {
    logic [1:0] grp;
    logic fault;
    logic [7:0] code;
    logic kernel_world;
    logic stream_secure;
    logic [63:0] addr;
  } tqu_rsp_t;
endpackage

// ### rtl/tqu_top.sv
// Notes on behaviour
// [R1] id register reports query facility present
// [R2] no fault events or stalls, code only
// [R3] guest group: stage 1, kernel world only
// [R4] general always; secure and guest optional
// [R5] one lookup per group, groups concurrent
// [R6] access touches only its own group
// [R7] scope limits differ per group
// [R8] action sets read, instruction, privilege attributes
// [R9] three lookup kinds by scope
// [R10] software checks run clear, owns group
// [R11] software programs inputs before run
// [R12] result written, then run flag cleared
// [R13] result derived like ordinary transaction
// [R14] lookup starts within bounded delay
// [R15] invalidation makes in-flight lookups retry
// [R16] invalidation need not wait for queries
// [R17] sync waits for table flag updates
// [R18] secure streams answered only to secure
// [R19] domain comes from stream configuration
// [R20] full 64-bit address, ordinary range checks
// [R21] clearing enable clears run flag
// [R22] software never writes group while running
// [R23] scope 00 reserved, invalid request error
// [R24] inputs captured when run is set
module tqu_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output tqu_pkg::tqu_req_t walk_req,
  output logic walk_req_valid,
  input wire logic walk_req_ready,
  input wire logic walk_rsp_valid,
  input wire tqu_pkg::tqu_rsp_t walk_rsp,
  input wire logic inval_done,
  input wire logic sync_req,
  input wire logic hw_upd_pending,
  output logic sync_done
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic [2:0] run_ff, issued_ff, stale_ff, want, grant;
  logic [31:0] sid_ff [3];
  logic [31:0] ssid_ff [3];
  logic [31:0] alo_ff [3];
  logic [31:0] ahi_ff [3];
  logic [63:0] res_ff [3];
  tqu_pkg::tqu_req_t cap_ff [3];
  tqu_pkg::tqu_req_t req_ff;
  logic [1:0] en_ff, rr_ff, wg, rg, pick_g;
  logic [11:0] waddr_ff, raddr_ff;
  logic wpend_ff, rpend_ff, hready_ff, hresp_ff, req_v_ff;
  logic sync_pend_ff, sync_done_ff, any_want, load;
  logic [31:0] hrdata_ff, nxt_rdata;

  assign hrdata = hrdata_ff;
  assign hreadyout = hready_ff;
  assign hresp = hresp_ff;
  assign walk_req = req_ff;
  assign walk_req_valid = req_v_ff;
  assign sync_done = sync_done_ff;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // [R4] groups beyond general exist by option
  function automatic logic [1:0] grp_of(input logic [11:0] a);
    if (a[11:8] == tqu_pkg::GEN_PAGE) begin
      return tqu_pkg::G_GEN;
    end else if (a[11:8] == tqu_pkg::SEC_PAGE && tqu_pkg::SECURE_PRESENT) begin
      return tqu_pkg::G_SEC;
    end else if (a[11:8] == tqu_pkg::GST_PAGE && tqu_pkg::GUEST_PRESENT) begin
      return tqu_pkg::G_GST;
    end else begin
      return tqu_pkg::G_NONE;
    end
  endfunction

  function automatic logic en_of(input logic [1:0] g, input logic [1:0] e);
    return (g == tqu_pkg::G_SEC) ? e[tqu_pkg::EN_S_BIT]
                                 : e[tqu_pkg::EN_NS_BIT];
  endfunction

  // [R7] scope limits checked before any walk
  function automatic logic [7:0] local_err(input tqu_pkg::tqu_req_t r);
    // [R23] reserved scope code
    if (r.scope == tqu_pkg::SC_RSVD) begin
      return tqu_pkg::FC_INVALID_REQUEST_ERROR;
    // [R3] guest page limited to stage 1
    end else if (r.grp == tqu_pkg::G_GST && r.scope != tqu_pkg::SC_S1) begin
      return tqu_pkg::FC_INVALID_REQUEST_ERROR;
    end else if (r.scope == tqu_pkg::SC_S2 && r.ssid_valid) begin
      return tqu_pkg::FC_INVALID_REQUEST_ERROR;
    end else if (r.secure && r.scope[1]) begin
      return tqu_pkg::FC_INV_STAGE;
    end else begin
      return 8'h00;
    end
  endfunction

  // [R24] snapshot of the programmed inputs
  function automatic tqu_pkg::tqu_req_t mk_req(input logic [1:0] g,
      input logic [31:0] sid, input logic [31:0] ssid,
      input logic [31:0] alo, input logic [31:0] ahi);
    tqu_pkg::tqu_req_t r;
    r.grp = g;
    // [R18] only the secure group may ask for secure streams
    r.secure = (g == tqu_pkg::G_SEC) & ssid[tqu_pkg::SECURE_STREAM_SELECT_BIT];
    r.stream = sid[15:0];
    r.ssid_valid = ssid[tqu_pkg::SSIDV_BIT];
    r.ssid = ssid[19:0];
    // [R9] scope picks one of the three lookup kinds, code 00 is reserved
    r.scope = tqu_pkg::tqu_scope_t'(alo[tqu_pkg::TYPE_LSB +: 2]);
    // [R8] access attributes travel with the address
    r.wr = alo[tqu_pkg::WR_BIT];
    r.instr = alo[tqu_pkg::INSTR_BIT];
    r.priv = alo[tqu_pkg::PRIV_BIT];
    // [R20] full 64-bit input, range checks in the walker
    r.addr = {ahi, alo[31:12], 12'h000};
    return r;
  endfunction

  // [R13] walker answers as for a normal transaction
  function automatic logic [63:0] mk_res(input logic [1:0] g,
      input tqu_pkg::tqu_rsp_t p);
    logic [7:0] code;
    code = p.code;
    // [R19] world comes from the stream, not the group
    if (g == tqu_pkg::G_GST && !p.kernel_world) begin
      code = tqu_pkg::FC_WORLD;
    end
    // [R18] secure stream data never leaves via other groups
    if (g != tqu_pkg::G_SEC && p.stream_secure) begin
      code = tqu_pkg::FC_WORLD;
    end
    // [R2] a failure shows only as a code in the result
    if (p.fault || code != p.code) begin
      return {52'h0, code, 3'h0, 1'b1};
    end
    return {p.addr[63:12], 12'h000};
  endfunction

  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  // reads take one wait state so a write just before is seen
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wpend_ff <= 1'b0;
      rpend_ff <= 1'b0;
      waddr_ff <= 12'h000;
      raddr_ff <= 12'h000;
      hready_ff <= 1'b1;
      hresp_ff <= 1'b0;
      hrdata_ff <= tqu_pkg::RST_WORD;
    end else begin
      wpend_ff <= hsel & htrans[1] & hready & hwrite;
      if (hsel & htrans[1] & hready) begin
        waddr_ff <= haddr[11:0];
        raddr_ff <= haddr[11:0];
      end
      if (hsel & htrans[1] & hready & !hwrite) begin
        rpend_ff <= 1'b1;
        hready_ff <= 1'b0;
      end else begin
        rpend_ff <= 1'b0;
        hready_ff <= 1'b1;
      end
      if (rpend_ff) begin
        hrdata_ff <= nxt_rdata;
      end
    end
  end

  assign rg = grp_of(raddr_ff);
  assign wg = grp_of(waddr_ff);

  always_comb begin
    nxt_rdata = tqu_pkg::RST_WORD;
    // [R1] presence bits for discovery
    if (raddr_ff == tqu_pkg::ID_OFS) begin
      nxt_rdata = {29'h0, tqu_pkg::SECURE_PRESENT, tqu_pkg::GUEST_PRESENT,
                   tqu_pkg::QUERY_PRESENT};
    end else if (raddr_ff == tqu_pkg::EN_OFS) begin
      nxt_rdata = {30'h0, en_ff};
    end else if (rg != tqu_pkg::G_NONE) begin
      if (raddr_ff[7:0] == tqu_pkg::CTRL_OFS) begin
        nxt_rdata = {31'h0, run_ff[rg]};
      end else if (raddr_ff[7:0] == tqu_pkg::SID_OFS) begin
        nxt_rdata = sid_ff[rg];
      end else if (raddr_ff[7:0] == tqu_pkg::SSID_OFS) begin
        nxt_rdata = ssid_ff[rg];
      end else if (raddr_ff[7:0] == tqu_pkg::ALO_OFS) begin
        nxt_rdata = alo_ff[rg];
      end else if (raddr_ff[7:0] == tqu_pkg::AHI_OFS) begin
        nxt_rdata = ahi_ff[rg];
      end else if (raddr_ff[7:0] == tqu_pkg::RLO_OFS) begin
        nxt_rdata = res_ff[rg][31:0];
      end else if (raddr_ff[7:0] == tqu_pkg::RHI_OFS) begin
        nxt_rdata = res_ff[rg][63:32];
      end
    end
  end

  // ---------------------------------------------------------------
  // input registers
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_ff <= tqu_pkg::RST_EN;
      for (int i = 0; i < 3; i++) begin
        sid_ff[i] <= tqu_pkg::RST_WORD;
        ssid_ff[i] <= tqu_pkg::RST_WORD;
        alo_ff[i] <= tqu_pkg::RST_WORD;
        ahi_ff[i] <= tqu_pkg::RST_WORD;
      end
    end else if (wpend_ff) begin
      if (waddr_ff == tqu_pkg::EN_OFS) begin
        en_ff <= hwdata[1:0];
      // [R6] a write lands in its own group, ignored while running
      end else if (wg != tqu_pkg::G_NONE && !run_ff[wg]) begin
        if (waddr_ff[7:0] == tqu_pkg::SID_OFS) begin
          sid_ff[wg] <= hwdata;
        end else if (waddr_ff[7:0] == tqu_pkg::SSID_OFS) begin
          ssid_ff[wg] <= hwdata;
        end else if (waddr_ff[7:0] == tqu_pkg::ALO_OFS) begin
          alo_ff[wg] <= hwdata;
        end else if (waddr_ff[7:0] == tqu_pkg::AHI_OFS) begin
          ahi_ff[wg] <= hwdata;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // walker request port
  // ---------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      want[i] = run_ff[i] & !issued_ff[i] & en_of(2'(i), en_ff) &
                (local_err(cap_ff[i]) == 8'h00);
    end
  end

  // [R14] round robin gives every group a bounded wait
  always_comb begin
    pick_g = tqu_pkg::G_GEN;
    any_want = 1'b0;
    for (int i = 2; i >= 0; i--) begin
      if (want[2'((int'(rr_ff) + 1 + i) % 3)]) begin
        pick_g = 2'((int'(rr_ff) + 1 + i) % 3);
        any_want = 1'b1;
      end
    end
    load = any_want & (!req_v_ff | walk_req_ready);
    grant = load ? (3'b001 << pick_g) : 3'b000;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_v_ff <= 1'b0;
      req_ff <= '0;
      rr_ff <= tqu_pkg::G_GST;
    end else if (!req_v_ff | walk_req_ready) begin
      req_v_ff <= any_want;
      if (any_want) begin
        req_ff <= cap_ff[pick_g];
        rr_ff <= pick_g;
      end
    end
  end

  // ---------------------------------------------------------------
  // group engines
  // ---------------------------------------------------------------
  // [R5] each group holds one lookup, all run side by side
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_ff <= 3'h0;
      issued_ff <= 3'h0;
      stale_ff <= 3'h0;
      for (int i = 0; i < 3; i++) begin
        res_ff[i] <= {2{tqu_pkg::RST_WORD}};
        cap_ff[i] <= '0;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (walk_rsp_valid && walk_rsp.grp == 2'(i) && issued_ff[i]) begin
          issued_ff[i] <= 1'b0;
          stale_ff[i] <= 1'b0;
        end else if (grant[i]) begin
          issued_ff[i] <= 1'b1;
        // [R15] answers in flight at invalidation are retried
        end else if (issued_ff[i] && (inval_done || !en_of(2'(i), en_ff)))
        begin
          stale_ff[i] <= 1'b1;
        end
        // [R21] enable low aborts the group's query
        if (!en_of(2'(i), en_ff)) begin
          run_ff[i] <= 1'b0;
        end else if (wpend_ff && wg == 2'(i) && !run_ff[i] &&
                     waddr_ff[7:0] == tqu_pkg::CTRL_OFS &&
                     hwdata[tqu_pkg::RUN_BIT]) begin
          // [R24] freeze the inputs as the run flag is set
          run_ff[i] <= 1'b1;
          cap_ff[i] <= mk_req(2'(i), sid_ff[i], ssid_ff[i], alo_ff[i],
                              ahi_ff[i]);
        end else if (run_ff[i] && !issued_ff[i] &&
                     local_err(cap_ff[i]) != 8'h00) begin
          run_ff[i] <= 1'b0;
          res_ff[i] <= {52'h0, local_err(cap_ff[i]), 4'h1};
        // [R12] result and run clear land on the same edge
        end else if (run_ff[i] && walk_rsp_valid && issued_ff[i] &&
                     walk_rsp.grp == 2'(i) && !stale_ff[i] && !inval_done)
        begin
          run_ff[i] <= 1'b0;
          res_ff[i] <= mk_res(2'(i), walk_rsp);
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // sync
  // ---------------------------------------------------------------
  // [R16] sync never waits on queries, only on table updates
  // [R17] done once table flag updates are visible
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_pend_ff <= 1'b0;
      sync_done_ff <= 1'b0;
    end else begin
      sync_pend_ff <= sync_req | (sync_pend_ff & hw_upd_pending);
      sync_done_ff <= sync_pend_ff & !hw_upd_pending;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_rsvd_scope;
    run_ff[0] && !issued_ff[0] && en_ff[0] &&
    cap_ff[0].scope == tqu_pkg::SC_RSVD
    |=> !run_ff[0] && res_ff[0][11:4] == tqu_pkg::FC_INVALID_REQUEST_ERROR && res_ff[0][0];
  endproperty
  a_rsvd_scope: assert property (p_rsvd_scope) // [R23]
    else $error("reserved scope not refused");

  property p_guest_s1;
    req_v_ff && req_ff.grp == tqu_pkg::G_GST |-> req_ff.scope == tqu_pkg::SC_S1;
  endproperty
  a_guest_s1: assert property (p_guest_s1) // [R3]
    else $error("guest group issued non stage 1 lookup");

  property p_gen_nonsec;
    req_v_ff && req_ff.grp != tqu_pkg::G_SEC |-> !req_ff.secure;
  endproperty
  a_gen_nonsec: assert property (p_gen_nonsec) // [R18]
    else $error("secure lookup from nonsecure group");

  property p_one_per_group;
    grant != 3'h0 |-> (grant & issued_ff) == 3'h0;
  endproperty
  a_one_per_group: assert property (p_one_per_group) // [R5]
    else $error("second lookup issued for busy group");

  property p_enable_abort;
    !en_ff[0] |=> !run_ff[0] && !run_ff[2];
  endproperty
  a_enable_abort: assert property (p_enable_abort) // [R21]
    else $error("run flag kept with enable low");

  property p_capture_hold;
    run_ff[1] && $past(run_ff[1]) |-> $stable(cap_ff[1]);
  endproperty
  a_capture_hold: assert property (p_capture_hold) // [R24]
    else $error("captured inputs changed during query");

  property p_stale_drop;
    walk_rsp_valid && walk_rsp.grp == tqu_pkg::G_GEN && issued_ff[0] &&
    inval_done |=> $stable(res_ff[0]) && !issued_ff[0];
  endproperty
  a_stale_drop: assert property (p_stale_drop) // [R15]
    else $error("stale answer used as result");

  property p_sync;
    sync_req ##1 !hw_upd_pending |=> sync_done_ff;
  endproperty
  a_sync: assert property (p_sync) // [R17]
    else $error("sync not done after updates drained");

  property p_start_bound;
    (want[0] && walk_req_ready) [*3] |-> ##[0:2] grant[0];
  endproperty
  a_start_bound: assert property (p_start_bound) // [R14]
    else $error("waiting group not granted in time");
endmodule

// ### bench/test_translation_query_unit.sv
module test_translation_query_unit;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(nm, e, g) begin \
    n_compared++; \
    if ((g) !== (e)) begin \
      errors++; \
      $display("unexpected %s exp %h got %h", nm, e, g); \
    end \
  end
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, e;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, walk_req_valid, sync_done;
  logic walk_req_ready = 0, walk_rsp_valid = 0, inval_done = 0;
  logic sync_req = 0, hw_upd_pending = 0, rd_dph = 0;
  tqu_pkg::tqu_req_t walk_req;
  tqu_pkg::tqu_rsp_t walk_rsp = '0;
  tqu_pkg::tqu_req_t exp_req [4];
  logic exp_ok [4] = '{default: 1'b0};
  logic [31:0] res_hi [4], res_lo [4], rnd = 32'h3985, rdq [$];
  int errors = 0, n_compared = 0, cyc = 0;
  assign hready = hreadyout;

  tqu_top tqu_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .walk_req(walk_req),
    .walk_req_valid(walk_req_valid), .walk_req_ready(walk_req_ready),
    .walk_rsp_valid(walk_rsp_valid), .walk_rsp(walk_rsp),
    .inval_done(inval_done), .sync_req(sync_req),
    .hw_upd_pending(hw_upd_pending), .sync_done(sync_done));

  initial begin
    forever #50 hclk = ~hclk;
  end

  // ---------------------------------------------------------------
  // helpers and bus cycles
  // ---------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  function automatic logic [31:0] ga(input logic [1:0] g,
                                     input logic [7:0] o);
    logic [3:0] p;
    p = (g == tqu_pkg::G_GEN) ? tqu_pkg::GEN_PAGE :
        (g == tqu_pkg::G_SEC) ? tqu_pkg::SEC_PAGE : tqu_pkg::GST_PAGE;
    return {20'h0, p, o};
  endfunction

  task automatic xfer(input logic w, input logic [31:0] a,
                      input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  // the monitor pops this note when the read data phase ends
  task automatic rd(input logic [31:0] a, input logic [31:0] x);
    rdq.push_back(x);
    rnd = lfsr(rnd);
    xfer(1'b0, a, rnd);
  endtask

  task automatic start(input logic [1:0] g, input logic ss, input logic sv,
                       input tqu_pkg::tqu_scope_t sc, input logic walk);
    logic [15:0] st;
    logic [19:0] sd, al;
    logic [2:0] at;
    // group idle before it is programmed
    rd(ga(g, tqu_pkg::CTRL_OFS), 32'h0);
    st = rnd[15:0];
    rnd = lfsr(rnd);
    sd = rnd[19:0];
    at = rnd[22:20];
    rnd = lfsr(rnd);
    al = rnd[31:12];
    rnd = lfsr(rnd);
    exp_req[g] = '{grp: g, secure: ss, stream: st, ssid_valid: sv,
      ssid: sd, scope: sc, wr: at[0], instr: at[1], priv: at[2],
      addr: {rnd, al, 12'h000}};
    exp_ok[g] = walk;
    // inputs land before the run write
    wr(ga(g, tqu_pkg::SID_OFS), {16'h0, st});
    wr(ga(g, tqu_pkg::SSID_OFS), {ss, sv, 10'h0, sd});
    wr(ga(g, tqu_pkg::ALO_OFS), {al, 2'b00, sc, 1'b0, at, 4'h0});
    wr(ga(g, tqu_pkg::AHI_OFS), rnd);
    wr(ga(g, tqu_pkg::CTRL_OFS), 32'h1);
  endtask

  task automatic take;
    walk_req_ready <= 1'b1;
    do @(posedge hclk); while (walk_req_valid !== 1'b1);
    walk_req_ready <= 1'b0;
    // one edge with ready low before any next handshake
    @(posedge hclk);
  endtask

  task automatic rsp(input logic [1:0] g, input logic f, input logic [7:0] c,
                     input logic kw, input logic ss, input logic [51:0] a);
    walk_rsp <= '{grp: g, fault: f, code: c, kernel_world: kw,
      stream_secure: ss, addr: {a, 12'h000}};
    walk_rsp_valid <= 1'b1;
    @(posedge hclk);
    walk_rsp_valid <= 1'b0;
    // an idle answer bus shows no stale result
    walk_rsp <= ~walk_rsp;
  endtask

  task automatic chk_res(input logic [1:0] g);
    rd(ga(g, tqu_pkg::CTRL_OFS), 32'h0);
    rd(ga(g, tqu_pkg::RHI_OFS), res_hi[g]);
    rd(ga(g, tqu_pkg::RLO_OFS), res_lo[g]);
  endtask

  task automatic fin(input logic [1:0] g, input logic f, input logic [7:0] c,
                     input logic kw, input logic ss);
    logic [51:0] a;
    a[51:20] = rnd;
    rnd = lfsr(rnd);
    a[19:0] = rnd[19:0];
    rsp(g, f, c, kw, ss, a);
    // world checks: guest needs kernel world, secure only via secure
    if (f || (g == tqu_pkg::G_GST && !kw) || (g != tqu_pkg::G_SEC && ss))
    begin
      res_hi[g] = 32'h0;
      res_lo[g] = {20'h0, f ? c : tqu_pkg::FC_WORLD, 4'h1};
    end else begin
      res_hi[g] = a[51:20];
      res_lo[g] = {a[19:0], 12'h000};
    end
    exp_ok[g] = 1'b0;
    chk_res(g);
  endtask

  task automatic lerr(input logic [1:0] g, input logic ss, input logic sv,
                      input tqu_pkg::tqu_scope_t sc, input logic [7:0] c);
    start(g, ss, sv, sc, 1'b0);
    @(posedge hclk);
    res_hi[g] = 32'h0;
    res_lo[g] = {20'h0, c, 4'h1};
    chk_res(g);
  endtask

  task automatic sync_t(input int hold);
    logic seen;
    seen = 1'b0;
    hw_upd_pending <= (hold > 0);
    sync_req <= 1'b1;
    @(posedge hclk);
    sync_req <= 1'b0;
    repeat (hold) begin
      @(posedge hclk);
      `CHK("sync_early", 1'b0, sync_done)
    end
    hw_upd_pending <= 1'b0;
    repeat (4) begin
      @(posedge hclk);
      if (sync_done === 1'b1) seen = 1'b1;
    end
    `CHK("sync_done", 1'b1, seen)
  endtask

  task test_done;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // output monitor and timeout
  // ---------------------------------------------------------------
  always @(posedge hclk) begin
    cyc++;
    if (!hresetn) rd_dph <= 1'b0;
    else if (hreadyout === 1'b1) begin
      if (rd_dph) begin
        e = rdq.pop_front();
        `CHK("hrdata", e, hrdata)
        `CHK("hresp", 1'b0, hresp)
      end
      rd_dph <= hsel && htrans[1] && !hwrite;
    end
    if (walk_req_valid === 1'b1 && walk_req_ready === 1'b1) begin
      `CHK("walk_expected", 1'b1, exp_ok[walk_req.grp])
      `CHK("walk_req", exp_req[walk_req.grp], walk_req)
    end
    // generous ceiling: the whole sequence needs about four hundred cycles
    if (cyc == 8000) begin
      errors++;
      test_done();
    end
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    wr(tqu_pkg::ID_OFS, 32'h0);
    rd(tqu_pkg::ID_OFS, 32'h7);
    rd(tqu_pkg::EN_OFS, 32'h0);
    wr(32'h0F0, rnd);
    rd(32'h0F0, 32'h0);
    rd(ga(tqu_pkg::G_GEN, tqu_pkg::SID_OFS), tqu_pkg::RST_WORD);
    wr(ga(tqu_pkg::G_GEN, tqu_pkg::CTRL_OFS), 32'h1);
    rd(ga(tqu_pkg::G_GEN, tqu_pkg::CTRL_OFS), 32'h0);
    wr(tqu_pkg::EN_OFS, 32'h3);
    rd(tqu_pkg::EN_OFS, 32'h3);
    // three groups in flight at once, answered in reverse order
    start(tqu_pkg::G_GEN, 1'b0, 1'b1, tqu_pkg::SC_BOTH, 1'b1);
    start(tqu_pkg::G_SEC, 1'b1, 1'b0, tqu_pkg::SC_S1, 1'b1);
    start(tqu_pkg::G_GST, 1'b0, 1'b0, tqu_pkg::SC_S1, 1'b1);
    repeat (3) take();
    for (int g = 2; g >= 0; g--) begin
      rd(ga(tqu_pkg::G_GEN, tqu_pkg::CTRL_OFS), 32'h1);
      fin(2'(g), 1'b0, 8'h00, 1'b1, g == 1);
    end
    start(tqu_pkg::G_GST, 1'b0, 1'b0, tqu_pkg::SC_S1, 1'b1);
    take();
    fin(tqu_pkg::G_GST, 1'b0, 8'h00, 1'b0, 1'b0);
    start(tqu_pkg::G_GEN, 1'b0, 1'b0, tqu_pkg::SC_S2, 1'b1);
    take();
    fin(tqu_pkg::G_GEN, 1'b0, 8'h00, 1'b1, 1'b1);
    start(tqu_pkg::G_SEC, 1'b0, 1'b0, tqu_pkg::SC_S2, 1'b1);
    take();
    fin(tqu_pkg::G_SEC, 1'b1, 8'h5A, 1'b1, 1'b0);
    lerr(tqu_pkg::G_GEN, 1'b0, 1'b0, tqu_pkg::SC_RSVD,
         tqu_pkg::FC_INVALID_REQUEST_ERROR);
    lerr(tqu_pkg::G_GST, 1'b0, 1'b0, tqu_pkg::SC_BOTH,
         tqu_pkg::FC_INVALID_REQUEST_ERROR);
    lerr(tqu_pkg::G_GEN, 1'b0, 1'b1, tqu_pkg::SC_S2,
         tqu_pkg::FC_INVALID_REQUEST_ERROR);
    lerr(tqu_pkg::G_SEC, 1'b1, 1'b0, tqu_pkg::SC_BOTH,
         tqu_pkg::FC_INV_STAGE);
    // stale answer after invalidation must be retried
    start(tqu_pkg::G_GEN, 1'b0, 1'b1, tqu_pkg::SC_S1, 1'b1);
    take();
    inval_done <= 1'b1;
    @(posedge hclk);
    inval_done <= 1'b0;
    rsp(tqu_pkg::G_GEN, 1'b0, 8'h00, 1'b1, 1'b0, {20'h0, rnd});
    rd(ga(tqu_pkg::G_GEN, tqu_pkg::CTRL_OFS), 32'h1);
    take();
    // an answer arriving with the invalidation is dropped as well
    inval_done <= 1'b1;
    rsp(tqu_pkg::G_GEN, 1'b0, 8'h00, 1'b1, 1'b0, {20'h0, rnd});
    inval_done <= 1'b0;
    rd(ga(tqu_pkg::G_GEN, tqu_pkg::CTRL_OFS), 32'h1);
    take();
    fin(tqu_pkg::G_GEN, 1'b0, 8'h00, 1'b1, 1'b0);
    // dropping the nonsecure enable leaves the secure group running
    start(tqu_pkg::G_SEC, 1'b1, 1'b0, tqu_pkg::SC_S1, 1'b1);
    start(tqu_pkg::G_GEN, 1'b0, 1'b0, tqu_pkg::SC_BOTH, 1'b1);
    repeat (2) take();
    wr(tqu_pkg::EN_OFS, 32'h2);
    rd(ga(tqu_pkg::G_SEC, tqu_pkg::CTRL_OFS), 32'h1);
    rsp(tqu_pkg::G_GEN, 1'b0, 8'h00, 1'b1, 1'b0, {20'h0, rnd});
    exp_ok[tqu_pkg::G_GEN] = 1'b0;
    chk_res(tqu_pkg::G_GEN);
    fin(tqu_pkg::G_SEC, 1'b0, 8'h00, 1'b1, 1'b1);
    sync_t(0);
    sync_t(4);
    test_done();
  end
endmodule
